// >>> host_model.sv
// host side of the register port: one access at a time, strobe for one cycle
// assumes the slice samples strobes and answers on the rising core_clk
`default_nettype none

module host_model (
	input  wire logic        core_clk,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_valid,
	output logic [11:0]      reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [31:0]      reg_wdata,
	output logic             reg_wide,
	output logic             uart_mode,
	output logic [15:0]      command_header
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_addr = 12'h000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h00000000;
		reg_wide = 1'b0;
		uart_mode = 1'b0;
		command_header = 16'h0000;
	end

	// released address, data and header lines show inverted values so stale data never looks valid
	task automatic access(input logic [11:0] a, input logic [31:0] d, input logic w,
			input logic wide, input logic uart, output logic [31:0] q, output logic ok);
		logic [15:0] hdr;
		hdr = {a, w, 3'h0};
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= ~w;
		reg_wide <= wide;
		uart_mode <= uart;
		command_header <= hdr;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		command_header <= ~hdr;
		uart_mode <= 1'b0;
		#1;
		q = rd_data;
		ok = w | rd_valid;
	endtask
endmodule // host_model

`default_nettype wire

// >>> metering_config_register_slice.sv
// register slice of a metering device: identity, start control, setup words,
// zero-crossing angle timers and serial-link readback aids
// assumes the serial engine on core_clk presents decoded accesses here
`include "metering_slice_cfg.svh"
`default_nettype none

module metering_config_register_slice #(
	parameter logic [31:0] IDENT_UPPER = 32'h0000a5a5, // arbitrary value
	parameter logic [31:0] IDENT_LOWER = 32'h00005a5a  // arbitrary value
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [11:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wide,
	input  wire logic        uart_mode,
	input  wire logic [15:0] command_header,
	input  wire logic        volt_a_pos,
	input  wire logic        curr_a_pos,
	input  wire logic        curr_b_pos,
	input  wire logic [15:0] sign_flags_in,
	input  wire logic [31:0] measured_period,
	output logic [31:0]      rd_data,
	output logic             rd_valid,
	output logic             measure_active,
	output logic [31:0]      line_period,
	output logic [2:0]       hpf_corner,
	output logic [15:0]      setup_one,
	output logic [15:0]      pulse_setup,
	output logic [15:0]      comp_setup,
	output logic [15:0]      acc_setup,
	output logic [15:0]      pq_setup,
	output logic [15:0]      pulse_one_div,
	output logic [15:0]      pulse_two_div,
	output logic [15:0]      sag_cycles,
	output logic [15:0]      surge_cycles,
	output logic [15:0]      zx_timeout,
	output logic [15:0]      zx_threshold,
	output logic [15:0]      zx_setup
);

	// ----------------------------------------
	// checksum helpers
	// ----------------------------------------
	function automatic logic [15:0] crc_bits(input logic [15:0] seed,
		input logic [31:0] data, input logic wide);
		logic [15:0] c;
		logic        fb;
		c = seed;
		for (int i = 31; i >= 0; i--) begin
			if (wide || i < 16) begin
				fb = c[15] ^ data[i];
				c = {c[14:0], 1'b0};
				if (fb) begin
					c = c ^ `CRC_POLY;
				end
			end
		end
		return c;
	endfunction

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [15:0] run_reg;
	logic [15:0] setup_two_reg;
	logic [31:0] user_period_reg;
	logic [15:0] vc_angle_reg;
	logic [15:0] cc_angle_reg;
	logic [15:0] setup_crc_reg;
	logic [15:0] serial_crc_reg;
	logic [15:0] last_short_reg;
	logic [15:0] last_cmd_reg;
	logic [31:0] rd_next;
	logic        rd_hit;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			run_reg         <= `RST_ZERO16;
			setup_one       <= `RST_SETUP_ONE;
			sag_cycles      <= `RST_ALL_ONES16;
			surge_cycles    <= `RST_ALL_ONES16;
			pulse_setup     <= `RST_ZERO16;
			comp_setup      <= `RST_ZERO16;
			acc_setup       <= `RST_ZERO16;
			pq_setup        <= `RST_ZERO16;
			pulse_one_div   <= `RST_ALL_ONES16;
			pulse_two_div   <= `RST_ALL_ONES16;
			zx_timeout      <= `RST_ALL_ONES16;
			zx_threshold    <= `RST_ZX_THRESH;
			zx_setup        <= `RST_ZERO16;
			setup_two_reg   <= `RST_SETUP_TWO;
			user_period_reg <= `RST_USER_PERIOD;
		end else if (reg_wr) begin
			// read-only offsets fall through untouched
			case (reg_addr)
				`OFS_MEASURE_START: run_reg       <= reg_wdata[15:0];
				`OFS_SETUP_ONE:     setup_one     <= reg_wdata[15:0];
				`OFS_SAG_CYC:       sag_cycles    <= reg_wdata[15:0];
				`OFS_SURGE_CYC:     surge_cycles  <= reg_wdata[15:0];
				`OFS_PULSE_SETUP:   pulse_setup   <= reg_wdata[15:0];
				`OFS_COMP_SETUP:    comp_setup    <= reg_wdata[15:0];
				`OFS_ACC_SETUP:     acc_setup     <= reg_wdata[15:0];
				`OFS_PQ_SETUP:      pq_setup      <= reg_wdata[15:0];
				`OFS_PULSE_ONE_DIV: pulse_one_div <= reg_wdata[15:0];
				`OFS_PULSE_TWO_DIV: pulse_two_div <= reg_wdata[15:0];
				`OFS_ZX_TIMEOUT:    zx_timeout    <= reg_wdata[15:0];
				`OFS_ZX_THRESH:     zx_threshold  <= reg_wdata[15:0];
				`OFS_ZX_SETUP:      zx_setup      <= reg_wdata[15:0];
				`OFS_SETUP_TWO:     setup_two_reg <= reg_wdata[15:0];
				`OFS_USER_PERIOD:   user_period_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// derived control
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			measure_active <= 1'b0;
			line_period    <= `RST_USER_PERIOD;
			hpf_corner     <= 3'h0;
		end else begin
			measure_active <= (run_reg == `RUN_START_VALUE);
			line_period    <= setup_two_reg[`USER_PERIOD_SEL_BIT] ?
				user_period_reg : measured_period;
			hpf_corner     <= setup_two_reg[`HPF_CORNER_MSB:`HPF_CORNER_LSB];
		end
	end

	// ----------------------------------------
	// configuration checksum
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			setup_crc_reg <= `RST_ZERO16;
		end else begin
			setup_crc_reg <= crc_bits(crc_bits(crc_bits(crc_bits(crc_bits(crc_bits(
				crc_bits(`CRC_SEED, {setup_one, sag_cycles}, 1'b1),
				{surge_cycles, pulse_setup}, 1'b1),
				{comp_setup, acc_setup}, 1'b1),
				{pq_setup, pulse_one_div}, 1'b1),
				{pulse_two_div, zx_timeout}, 1'b1),
				{zx_threshold, zx_setup}, 1'b1),
				{16'h0000, setup_two_reg}, 1'b0);
		end
	end

	// ----------------------------------------
	// zero-crossing angle timers
	// ----------------------------------------
	metering_slice_pkg::angle_state_t vc_state_reg;
	metering_slice_pkg::angle_state_t cc_state_reg;
	logic [15:0] vc_cnt_reg;
	logic [15:0] cc_cnt_reg;
	logic        volt_a_prev;
	logic        curr_a_prev;
	logic        curr_b_prev;
	logic        volt_a_fall;
	logic        curr_a_fall;
	logic        curr_b_fall;

	assign volt_a_fall = volt_a_prev & ~volt_a_pos;
	assign curr_a_fall = curr_a_prev & ~curr_a_pos;
	assign curr_b_fall = curr_b_prev & ~curr_b_pos;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			volt_a_prev <= 1'b0;
			curr_a_prev <= 1'b0;
			curr_b_prev <= 1'b0;
		end else begin
			volt_a_prev <= volt_a_pos;
			curr_a_prev <= curr_a_pos;
			curr_b_prev <= curr_b_pos;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			vc_state_reg <= metering_slice_pkg::ANG_IDLE;
			vc_cnt_reg   <= 16'h0000;
			vc_angle_reg <= `RST_ZERO16;
		end else if (!measure_active) begin
			vc_state_reg <= metering_slice_pkg::ANG_IDLE;
		end else begin
			case (vc_state_reg)
				metering_slice_pkg::ANG_IDLE: begin
					if (volt_a_fall) begin
						vc_cnt_reg   <= 16'h0000;
						vc_state_reg <= metering_slice_pkg::ANG_COUNT;
					end
				end
				metering_slice_pkg::ANG_COUNT: begin
					if (curr_a_fall) begin
						vc_angle_reg <= vc_cnt_reg;
						vc_state_reg <= metering_slice_pkg::ANG_IDLE;
					end else if (vc_cnt_reg != `ANGLE_MAX) begin
						vc_cnt_reg <= vc_cnt_reg + 16'h0001;
					end
				end
				default: vc_state_reg <= metering_slice_pkg::ANG_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cc_state_reg <= metering_slice_pkg::ANG_IDLE;
			cc_cnt_reg   <= 16'h0000;
			cc_angle_reg <= `RST_ZERO16;
		end else if (!measure_active) begin
			cc_state_reg <= metering_slice_pkg::ANG_IDLE;
		end else begin
			case (cc_state_reg)
				metering_slice_pkg::ANG_IDLE: begin
					if (curr_a_fall) begin
						cc_cnt_reg   <= 16'h0000;
						cc_state_reg <= metering_slice_pkg::ANG_COUNT;
					end
				end
				metering_slice_pkg::ANG_COUNT: begin
					if (curr_b_fall) begin
						cc_angle_reg <= cc_cnt_reg;
						cc_state_reg <= metering_slice_pkg::ANG_IDLE;
					end else if (cc_cnt_reg != `ANGLE_MAX) begin
						cc_cnt_reg <= cc_cnt_reg + 16'h0001;
					end
				end
				default: cc_state_reg <= metering_slice_pkg::ANG_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		rd_next = 32'h00000000;
		rd_hit  = 1'b1;
		case (reg_addr)
			`OFS_IDENT_UPPER:   rd_next = IDENT_UPPER;
			`OFS_IDENT_LOWER:   rd_next = IDENT_LOWER;
			`OFS_MEASURE_START: rd_next = {16'h0000, run_reg};
			`OFS_SETUP_ONE:     rd_next = {16'h0000, setup_one};
			`OFS_VC_ANGLE:      rd_next = {16'h0000, vc_angle_reg};
			`OFS_CC_ANGLE:      rd_next = {16'h0000, cc_angle_reg};
			`OFS_SAG_CYC:       rd_next = {16'h0000, sag_cycles};
			`OFS_SURGE_CYC:     rd_next = {16'h0000, surge_cycles};
			`OFS_PULSE_SETUP:   rd_next = {16'h0000, pulse_setup};
			`OFS_COMP_SETUP:    rd_next = {16'h0000, comp_setup};
			`OFS_ACC_SETUP:     rd_next = {16'h0000, acc_setup};
			`OFS_PQ_SETUP:      rd_next = {16'h0000, pq_setup};
			`OFS_PULSE_ONE_DIV: rd_next = {16'h0000, pulse_one_div};
			`OFS_PULSE_TWO_DIV: rd_next = {16'h0000, pulse_two_div};
			`OFS_ZX_TIMEOUT:    rd_next = {16'h0000, zx_timeout};
			`OFS_ZX_THRESH:     rd_next = {16'h0000, zx_threshold};
			`OFS_ZX_SETUP:      rd_next = {16'h0000, zx_setup};
			`OFS_SIGN_FLAGS:    rd_next = {16'h0000, sign_flags_in};
			`OFS_SETUP_CRC:     rd_next = {16'h0000, setup_crc_reg};
			`OFS_SERIAL_CRC:    rd_next = {16'h0000, serial_crc_reg};
			`OFS_LAST_SHORT:    rd_next = {16'h0000, last_short_reg};
			`OFS_LAST_CMD:      rd_next = {16'h0000, last_cmd_reg};
			`OFS_SETUP_TWO:     rd_next = {16'h0000, setup_two_reg};
			`OFS_USER_PERIOD:   rd_next = user_period_reg;
			default:            rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data  <= 32'h00000000;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= reg_rd;
			if (reg_rd) begin
				rd_data <= rd_hit ? rd_next : 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// serial-link readback aids
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			serial_crc_reg <= `RST_ZERO16;
			last_short_reg <= `RST_ZERO16;
			last_cmd_reg   <= `RST_ZERO16;
		end else begin
			if (reg_rd) begin
				serial_crc_reg <= crc_bits(`CRC_SEED, rd_next, reg_wide);
			end
			if ((reg_rd || reg_wr) && (uart_mode || !reg_wide)) begin
				last_short_reg <= reg_wr ? reg_wdata[15:0] : rd_next[15:0];
			end
			if ((reg_rd || reg_wr) && !uart_mode) begin
				last_cmd_reg <= command_header;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	run_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_wr && reg_addr == `OFS_MEASURE_START |=> ##1
		measure_active == ($past(reg_wdata[15:0], 2) == `RUN_START_VALUE))
		else $error("measure_active does not follow start write");
	idle_angle_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!measure_active |=> vc_state_reg == metering_slice_pkg::ANG_IDLE)
		else $error("angle timer ran while idle");
	serial_crc_a: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_rd |=> serial_crc_reg == crc_bits(`CRC_SEED, rd_data, $past(reg_wide)))
		else $error("serial crc mismatch");
	short_data_a: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_wr && !reg_wide |=> last_short_reg == $past(reg_wdata[15:0]))
		else $error("last short data not captured");
	cmd_capture_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(reg_wr || reg_rd) && !uart_mode |=> last_cmd_reg == $past(command_header))
		else $error("command header not captured");
	vc_angle_a: assert property (@(posedge core_clk) disable iff (!rstn)
		vc_state_reg == metering_slice_pkg::ANG_COUNT && measure_active && curr_a_fall
		|=> vc_angle_reg == $past(vc_cnt_reg))
		else $error("voltage-current angle not latched");
	cc_angle_a: assert property (@(posedge core_clk) disable iff (!rstn)
		cc_state_reg == metering_slice_pkg::ANG_COUNT && measure_active && curr_b_fall
		|=> cc_angle_reg == $past(cc_cnt_reg))
		else $error("current-current angle not latched");
	ro_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_wr && reg_addr == `OFS_LAST_SHORT && !reg_rd && reg_wide && !uart_mode
		|=> $stable(last_short_reg))
		else $error("read-only register changed by write");
	period_sel_a: assert property (@(posedge core_clk) disable iff (!rstn)
		setup_two_reg[`USER_PERIOD_SEL_BIT] && $stable(user_period_reg)
		|=> line_period == $past(user_period_reg))
		else $error("user period not selected");
	reset_vals_a: assert property (@(posedge core_clk)
		$rose(rstn) |-> zx_threshold == `RST_ZX_THRESH && zx_timeout == `RST_ALL_ONES16
		&& sag_cycles == `RST_ALL_ONES16 && pulse_one_div == `RST_ALL_ONES16)
		else $error("bad reset values");

endmodule // metering_config_register_slice
`default_nettype wire

// >>> metering_slice_cfg.svh
// register offsets, reset values, field positions and checksum constants
// assumes inclusion by the register slice and its bench
`ifndef METERING_SLICE_CFG_SVH
`define METERING_SLICE_CFG_SVH

`define OFS_IDENT_UPPER     12'h472
`define OFS_IDENT_LOWER     12'h473
`define OFS_MEASURE_START   12'h480
`define OFS_SETUP_ONE       12'h481
`define OFS_VC_ANGLE        12'h485
`define OFS_CC_ANGLE        12'h488
`define OFS_SAG_CYC         12'h48b
`define OFS_SURGE_CYC       12'h48c
`define OFS_PULSE_SETUP     12'h490
`define OFS_COMP_SETUP      12'h491
`define OFS_ACC_SETUP       12'h492
`define OFS_PQ_SETUP        12'h493
`define OFS_PULSE_ONE_DIV   12'h494
`define OFS_PULSE_TWO_DIV   12'h495
`define OFS_ZX_TIMEOUT      12'h498
`define OFS_ZX_THRESH       12'h499
`define OFS_ZX_SETUP        12'h49a
`define OFS_SIGN_FLAGS      12'h49d
`define OFS_SETUP_CRC       12'h4a8
`define OFS_SERIAL_CRC      12'h4a9
`define OFS_LAST_SHORT      12'h4ac
`define OFS_LAST_CMD        12'h4ae
`define OFS_SETUP_TWO       12'h4af
`define OFS_USER_PERIOD     12'h40e

`define RST_ZERO16          16'h0000
`define RST_SETUP_ONE       16'h0300
`define RST_ALL_ONES16      16'hffff
`define RST_ZX_THRESH       16'h0009
`define RST_SETUP_TWO       16'h0c00
`define RST_USER_PERIOD     32'h00500000
`define RUN_START_VALUE     16'h0001

`define USER_PERIOD_SEL_BIT 0
`define HPF_CORNER_MSB      3
`define HPF_CORNER_LSB      1

`define CRC_POLY            16'h1021
`define CRC_SEED            16'hffff
`define ANGLE_MAX           16'hffff

`endif

// >>> metering_slice_pkg.sv
// types used by the angle timers of the register slice
// assumes metering_slice_cfg.svh holds the numeric constants
`default_nettype none
package metering_slice_pkg;
	typedef enum logic [1:0] {
		ANG_IDLE  = 2'b01,
		ANG_COUNT = 2'b10
	} angle_state_t;
endpackage
`default_nettype wire

// >>> tb_top.sv
// self-checking bench of the metering register slice
// assumes host_model drives the register port; 25 MHz core_clk
`include "metering_slice_cfg.svh"
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] IDU = 32'h13572468; // arbitrary value
	localparam logic [31:0] IDL = 32'h9bdf0ace; // arbitrary value
	localparam logic [31:0] PAT = 32'hc33c5aa5;
	localparam logic [31:0] MP  = 32'h00412345;
	localparam logic [15:0] SGN = 16'h9c3e;

	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic volt_a_pos = 1'b1;
	logic curr_a_pos = 1'b1;
	logic curr_b_pos = 1'b1;
	logic [11:0] reg_addr;
	logic reg_wr, reg_rd, reg_wide, uart_mode, rd_valid, measure_active;
	logic [31:0] reg_wdata, rd_data, line_period, q, a1;
	logic [15:0] command_header, setup_one, pulse_setup, comp_setup, acc_setup, pq_setup;
	logic [15:0] pulse_one_div, pulse_two_div, sag_cycles, surge_cycles, zx_timeout;
	logic [15:0] zx_threshold, zx_setup;
	logic [2:0] hpf_corner;
	logic ok;
	int n_errors = 0;
	int checked = 0;

	typedef struct {logic [11:0] a; logic [31:0] rst; logic [31:0] m; logic wide;} row_t;
	row_t rows [21] = '{
		'{12'h472, IDU, 32'h0, 1'b1}, '{12'h473, IDL, 32'h0, 1'b1},
		'{12'h480, 32'h0, 32'hffff, 1'b0}, '{12'h481, 32'h0300, 32'hffff, 1'b0},
		'{12'h485, 32'h0, 32'h0, 1'b0}, '{12'h488, 32'h0, 32'h0, 1'b0},
		'{12'h48b, 32'hffff, 32'hffff, 1'b0}, '{12'h48c, 32'hffff, 32'hffff, 1'b0},
		'{12'h490, 32'h0, 32'hffff, 1'b0}, '{12'h491, 32'h0, 32'hffff, 1'b0},
		'{12'h492, 32'h0, 32'hffff, 1'b0}, '{12'h493, 32'h0, 32'hffff, 1'b0},
		'{12'h494, 32'hffff, 32'hffff, 1'b0}, '{12'h495, 32'hffff, 32'hffff, 1'b0},
		'{12'h498, 32'hffff, 32'hffff, 1'b0}, '{12'h499, 32'h0009, 32'hffff, 1'b0},
		'{12'h49a, 32'h0, 32'hffff, 1'b0}, '{12'h49d, {16'h0, SGN}, 32'h0, 1'b0},
		'{12'h4af, 32'h0c00, 32'hffff, 1'b0}, '{12'h40e, 32'h00500000, 32'hffffffff, 1'b1},
		'{12'h4b0, 32'h0, 32'h0, 1'b0}};
	logic [15:0] cw [13] = '{16'h0300, 16'hffff, 16'hffff, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'hffff, 16'hffff, 16'hffff, 16'h0009, 16'h0000, 16'h0c00};

	always #20 core_clk = ~core_clk;

	metering_config_register_slice #(.IDENT_UPPER(IDU), .IDENT_LOWER(IDL))
		i_metering_config_register_slice (
		.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_wide(reg_wide), .uart_mode(uart_mode),
		.command_header(command_header), .volt_a_pos(volt_a_pos), .curr_a_pos(curr_a_pos),
		.curr_b_pos(curr_b_pos), .sign_flags_in(SGN), .measured_period(MP),
		.rd_data(rd_data), .rd_valid(rd_valid), .measure_active(measure_active),
		.line_period(line_period), .hpf_corner(hpf_corner), .setup_one(setup_one),
		.pulse_setup(pulse_setup), .comp_setup(comp_setup), .acc_setup(acc_setup),
		.pq_setup(pq_setup), .pulse_one_div(pulse_one_div), .pulse_two_div(pulse_two_div),
		.sag_cycles(sag_cycles), .surge_cycles(surge_cycles), .zx_timeout(zx_timeout),
		.zx_threshold(zx_threshold), .zx_setup(zx_setup));

	host_model i_host_model (
		.core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_wide(reg_wide),
		.uart_mode(uart_mode), .command_header(command_header));

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic results;
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic wide = 1'b0,
			input logic uart = 1'b0);
		i_host_model.access(a, d, 1'b1, wide, uart, q, ok);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic wide = 1'b0);
		i_host_model.access(a, 32'h0, 1'b0, wide, 1'b0, q, ok);
		check_val($sformatf("read valid %h", a), 32'h1, {31'h0, ok});
		check_val($sformatf("read %h", a), exp, q);
	endtask

	// crc-16, msb first, over the low n bits of d
	function automatic logic [15:0] crc(input logic [15:0] s, input logic [31:0] d, input int n);
		logic fb;
		for (int i = n - 1; i >= 0; i--) begin
			fb = s[15] ^ d[i];
			s = {s[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
		end
		return s;
	endfunction

	function automatic logic [15:0] setup_crc();
		logic [15:0] s;
		s = `CRC_SEED;
		foreach (cw[i]) s = crc(s, {16'h0, cw[i]}, 16);
		return s;
	endfunction

	// sel 0: voltage a then current a falls k cycles apart; sel 1: current a then b
	task automatic falls(input int sel, input int k);
		@(posedge core_clk);
		if (sel == 0) volt_a_pos <= 1'b0; else curr_a_pos <= 1'b0;
		repeat (k) @(posedge core_clk);
		if (sel == 0) curr_a_pos <= 1'b0; else curr_b_pos <= 1'b0;
		repeat (3) @(posedge core_clk);
		volt_a_pos <= 1'b1;
		curr_a_pos <= 1'b1;
		curr_b_pos <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			rdc(rows[i].a, rows[i].rst, rows[i].wide);
			wr(rows[i].a, PAT, rows[i].wide);
			rdc(rows[i].a, (PAT & rows[i].m) | (rows[i].rst & ~rows[i].m), rows[i].wide);
		end
		@(posedge core_clk);
		rstn <= 1'b0;
		@(posedge core_clk);
		#1;
		check_val("sag reset", 32'hffff, {16'h0, sag_cycles});
		check_val("pulse one reset", 32'hffff, {16'h0, pulse_one_div});
		check_val("threshold reset", 32'h0009, {16'h0, zx_threshold});
		check_val("timeout reset", 32'hffff, {16'h0, zx_timeout});
		check_val("period reset", 32'h00500000, line_period);
		check_val("active reset", 32'h0, {31'h0, measure_active});
		check_val("surge reset", 32'hffff, {16'h0, surge_cycles});
		check_val("pulse two reset", 32'hffff, {16'h0, pulse_two_div});
		check_val("comp reset", 32'h0, {16'h0, comp_setup});
		check_val("setup one reset", 32'h0300, {16'h0, setup_one});
		check_val("pulse setup reset", 32'h0, {16'h0, pulse_setup});
		check_val("acc reset", 32'h0, {16'h0, acc_setup});
		check_val("pq reset", 32'h0, {16'h0, pq_setup});
		check_val("zx setup reset", 32'h0, {16'h0, zx_setup});
		check_val("hpf reset", 32'h0, {29'h0, hpf_corner});
		@(posedge core_clk);
		rstn <= 1'b1;
		rdc(12'h4a8, {16'h0, setup_crc()});
		wr(12'h491, 32'h0005);
		cw[4] = 16'h0005;
		settle();
		rdc(12'h4a8, {16'h0, setup_crc()});
		wr(12'h4af, 32'h000e);
		settle();
		check_val("hpf corner", 32'h7, {29'h0, hpf_corner});
		check_val("measured period", MP, line_period);
		wr(12'h40e, 32'h00123456, 1'b1);
		wr(12'h4af, 32'h0001);
		settle();
		check_val("user period", 32'h00123456, line_period);
		falls(0, 10);
		rdc(12'h485, 32'h0);
		wr(12'h480, 32'h0001);
		settle();
		check_val("active", 32'h1, {31'h0, measure_active});
		for (int s = 1; s >= 0; s--) begin
			falls(s, 10);
			i_host_model.access(s ? 12'h488 : 12'h485, 32'h0, 1'b0, 1'b0, 1'b0, a1, ok);
			check_val("angle range", 32'h1, {31'h0, a1 >= 32'h9 && a1 <= 32'hb});
			falls(s, 20);
			rdc(s ? 12'h488 : 12'h485, a1 + 32'ha);
		end
		wr(12'h480, 32'h0002);
		settle();
		check_val("stopped", 32'h0, {31'h0, measure_active});
		rdc(12'h4af, 32'h0001);
		rdc(12'h4a9, {16'h0, crc(`CRC_SEED, 32'h1, 16)});
		rdc(12'h472, IDU, 1'b1);
		rdc(12'h4a9, {16'h0, crc(`CRC_SEED, IDU, 32)});
		wr(12'h481, 32'h1357);
		rdc(12'h4ac, 32'h1357);
		wr(12'h40e, 32'habcd0123, 1'b1);
		wr(12'h4ac, PAT, 1'b1);
		rdc(12'h4ac, 32'h1357);
		wr(12'h493, 32'h0011);
		wr(12'h40e, 32'h00aa2468, 1'b1, 1'b1);
		rdc(12'h4ae, 32'h4938);
		wr(12'h40e, 32'h00aa2468, 1'b1, 1'b1);
		rdc(12'h4ac, 32'h2468);
		results();
	end

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		results();
	end
endmodule // tb_top

`default_nettype wire
